// file: rtl/wipe_pkg.sv
// Package: opcodes, timing, frame lengths and carrier types of the sequencer
package wipe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] OP_SMALL_REGION_WIPE     = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_WIPE       = 8'h52;
  localparam logic [7:0] OP_FULL_BLOCK_WIPE       = 8'hD8;
  localparam logic [7:0] OP_ARRAY_WIPE_A          = 8'hC7;
  localparam logic [7:0] OP_ARRAY_WIPE_B          = 8'h60;
  localparam logic [7:0] OP_WRITE_UNLOCK_CMD      = 8'h06;
  localparam logic [7:0] OP_FOUR_LINE_MODE_ENTRY  = 8'h38;

  ////////////////////////////////////////////////////////////////////////////
  // Frame lengths in serial clock edges
  localparam logic [5:0] SINGLE_OP_CLOCKS   = 6'h08;
  localparam logic [5:0] SINGLE_ADDR_CLOCKS = 6'h20;
  localparam logic [5:0] QUAD_OP_CLOCKS     = 6'h02;
  localparam logic [5:0] QUAD_ADDR_CLOCKS   = 6'h08;
  localparam logic [5:0] CLOCK_COUNT_MAX    = 6'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // Region layout and protection
  localparam logic [23:0] SECTOR_MASK     = 24'hFFF000;
  localparam logic [23:0] HALF_BLOCK_MASK = 24'hFF8000;
  localparam logic [23:0] BLOCK_MASK      = 24'hFF0000;
  localparam int          BLOCK_INDEX_MSB = 18;
  localparam int          BLOCK_INDEX_LSB = 16;
  localparam logic [3:0]  BLOCK_COUNT     = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic LATCH_RESET     = 1'b0;
  localparam logic FOUR_LINE_RESET = 1'b0;
  localparam logic SELECT_IDLE     = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLOCK_HZ       = 20_000_000;
  localparam int unsigned T_SECTOR_MS    = 40;
  localparam int unsigned T_HALF_MS      = 100;
  localparam int unsigned T_BLOCK_MS     = 150;
  localparam int unsigned T_ARRAY_MS     = 2000;

  // Milliseconds to system clock cycles
  function automatic int unsigned ms_to_cycles(input int unsigned ms);
    return ms * (CLOCK_HZ / 1000);
  endfunction : ms_to_cycles

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    WIPE_NONE, WIPE_SECTOR, WIPE_HALF, WIPE_BLOCK, WIPE_ARRAY
  } wipe_kind_t;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_WIPING = 2'b01
  } seq_state_t;

  typedef enum logic [1:0] {
    LEN_SHORT, LEN_OP, LEN_OP_ADDR, LEN_ODD
  } frame_len_t;

  typedef enum logic [2:0] {
    REJ_NONE, REJ_NO_LATCH, REJ_PROTECTED, REJ_FRAMING, REJ_BUSY
  } reject_t;

  typedef struct packed {
    wipe_kind_t  kind;
    logic [23:0] base;
  } wipe_req_t;

  typedef struct packed {
    logic [5:0]  clocks;
    logic        frame_tog;
    logic [7:0]  single_op;
    logic [7:0]  quad_op;
    logic [23:0] single_bits;
    logic [23:0] quad_bits;
  } link_capture_t;

  typedef struct packed {
    frame_len_t  len;
    logic [7:0]  op;
    logic [23:0] addr;
  } frame_t;

endpackage : wipe_pkg

// file: rtl/select_sync.sv
// Two-stage synchroniser for the select level
`timescale 1ns/1ps
`default_nettype none

module select_sync (
  input  wire logic clock,     // System clock
  input  wire logic resetn,    // Async reset, active low
  input  wire logic async_in,  // Level from the link side
  output var  logic sync_out   // Level in the system domain
);
  import wipe_pkg::*;

  logic stage1;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1   <= SELECT_IDLE;
      sync_out <= SELECT_IDLE;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : select_sync

`default_nettype wire

// file: rtl/link_shifter.sv
// Serial-clock front end: counts edges and shifts one- and four-line bits
`timescale 1ns/1ps
`default_nettype none

module link_shifter (
  input  wire logic                    sclk,    // Serial clock from host
  input  wire logic                    resetn,  // Async reset, active low
  input  wire logic                    cs_n,    // Select, active low
  input  wire logic [3:0]              dq_in,   // Data lines, dq_in[0] serial
  output var  wipe_pkg::link_capture_t capture  // Frame contents
);
  import wipe_pkg::*;

  logic frame_clear_n;
  logic frame_open;

  assign frame_clear_n = resetn & ~cs_n;

  // Frame marker, cleared while select is high
  always_ff @(posedge sclk or negedge frame_clear_n) begin
    if (!frame_clear_n) begin
      frame_open <= 1'b0;
    end else begin
      frame_open <= 1'b1;
    end
  end

  // Edge count and frame toggle, restart on a frame's first edge
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      capture.clocks    <= 6'h00;
      capture.frame_tog <= 1'b0;
    end else if (!cs_n) begin
      if (!frame_open) begin
        capture.clocks    <= 6'h01;
        capture.frame_tog <= ~capture.frame_tog;
      end else if (capture.clocks != CLOCK_COUNT_MAX) begin
        capture.clocks <= capture.clocks + 6'h01;
      end
    end
  end

  // Both readings shift at once; the system side picks one by mode
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      capture.single_bits <= 24'h000000;
      capture.quad_bits   <= 24'h000000;
      capture.single_op   <= 8'h00;
      capture.quad_op     <= 8'h00;
    end else if (!cs_n) begin
      capture.single_bits <= {capture.single_bits[22:0], dq_in[0]};
      capture.quad_bits   <= {capture.quad_bits[19:0], dq_in};
      if (frame_open && capture.clocks == SINGLE_OP_CLOCKS - 6'h01) begin
        capture.single_op <= {capture.single_bits[6:0], dq_in[0]};
      end
      if (frame_open && capture.clocks == QUAD_OP_CLOCKS - 6'h01) begin
        capture.quad_op <= {capture.quad_bits[3:0], dq_in};
      end
    end
  end

endmodule : link_shifter

`default_nettype wire

// file: rtl/wipe_sequencer.sv
// Erase command decoder and self-timed erase sequencer of a serial flash
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Sector opcode plus address wipes 4KB sector
// - Half-block opcode plus address wipes 32KB
// - Block opcode plus address wipes 64KB
// - Two opcodes both wipe whole array
// - Wipes accepted only with unlock latch set
// - Unlock command sets the unlock latch
// - Opcode then three address bytes accepted
// - Address wipes need select rise after byte
// - Array wipe needs select rise after opcode
// - Valid select rise starts timed erase
// - Busy one during cycle, zero after
// - Unlock latch cleared before cycle ends
// - Protected region wipes are not executed
// - Array wipe only with protection all zero
// - Wipes also work in four-line mode
// - Four-line bytes sent high nibble first
module wipe_sequencer #(
  parameter int unsigned SECTOR_WIPE_CYCLES =
    wipe_pkg::ms_to_cycles(wipe_pkg::T_SECTOR_MS),
  parameter int unsigned HALF_WIPE_CYCLES   =
    wipe_pkg::ms_to_cycles(wipe_pkg::T_HALF_MS),
  parameter int unsigned BLOCK_WIPE_CYCLES  =
    wipe_pkg::ms_to_cycles(wipe_pkg::T_BLOCK_MS),
  parameter int unsigned ARRAY_WIPE_CYCLES  =
    wipe_pkg::ms_to_cycles(wipe_pkg::T_ARRAY_MS)
) (
  input  wire logic                clock,                // System clock
  input  wire logic                resetn,               // Async reset
  input  wire logic                sclk,                 // Serial clock
  input  wire logic                cs_n,                 // Select, low
  input  wire logic [3:0]          dq_in,                // Data lines
  input  wire logic [3:0]          protect_level,        // Protect bits
  output var  logic                busy_flag_in_status,  // Erase running
  output var  logic                write_unlock_latch,   // Unlock latch
  output var  logic                four_line_protocol,   // Four-line mode
  output var  logic                wipe_start,           // Cycle start
  output var  wipe_pkg::wipe_req_t wipe_req,             // Region to wipe
  output var  logic                wipe_done,            // Cycle end
  output var  logic                reject_pulse,         // Wipe refused
  output var  wipe_pkg::reject_t   reject_reason         // Why refused
);
  import wipe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Pick opcode, address and length class of a finished frame
  function automatic frame_t decode_frame(input link_capture_t cap,
                                          input logic          quad);
    frame_t     f;
    logic [5:0] op_clk;
    logic [5:0] addr_clk;
    op_clk   = quad ? QUAD_OP_CLOCKS : SINGLE_OP_CLOCKS;
    addr_clk = quad ? QUAD_ADDR_CLOCKS : SINGLE_ADDR_CLOCKS;
    f.op     = quad ? cap.quad_op : cap.single_op;
    f.addr   = quad ? cap.quad_bits : cap.single_bits;
    if (cap.clocks == op_clk) begin
      f.len = LEN_OP;
    end else if (cap.clocks == addr_clk) begin
      f.len = LEN_OP_ADDR;
    end else if (cap.clocks > op_clk) begin
      f.len = LEN_ODD;
    end else begin
      f.len = LEN_SHORT;
    end
    return f;
  endfunction : decode_frame

  // Wipe kind named by an opcode, whatever the frame length
  function automatic wipe_kind_t opcode_kind(input logic [7:0] op);
    if (op == OP_SMALL_REGION_WIPE) begin
      return WIPE_SECTOR;
    end else if (op == OP_HALF_BLOCK_WIPE) begin
      return WIPE_HALF;
    end else if (op == OP_FULL_BLOCK_WIPE) begin
      return WIPE_BLOCK;
    end else if (op == OP_ARRAY_WIPE_A || op == OP_ARRAY_WIPE_B) begin
      return WIPE_ARRAY;
    end
    return WIPE_NONE;
  endfunction : opcode_kind

  // Top-down protection: level n covers the n highest blocks
  function automatic logic block_protected(input logic [3:0] level,
                                           input logic [2:0] index);
    if (level >= BLOCK_COUNT) begin
      return 1'b1;
    end
    return {1'b0, index} >= (BLOCK_COUNT - level);
  endfunction : block_protected

  // Region base from the upper address bits
  function automatic logic [23:0] region_base(input wipe_kind_t  kind,
                                              input logic [23:0] addr);
    unique case (kind)
      WIPE_SECTOR: return addr & SECTOR_MASK;
      WIPE_HALF:   return addr & HALF_BLOCK_MASK;
      WIPE_BLOCK:  return addr & BLOCK_MASK;
      WIPE_ARRAY:  return 24'h000000;
      default:     return 24'h000000;
    endcase
  endfunction : region_base

  // Erase time of a region, in cycles less one
  function automatic logic [31:0] wipe_load(input wipe_kind_t kind);
    unique case (kind)
      WIPE_SECTOR: return 32'(SECTOR_WIPE_CYCLES - 1);
      WIPE_HALF:   return 32'(HALF_WIPE_CYCLES - 1);
      WIPE_BLOCK:  return 32'(BLOCK_WIPE_CYCLES - 1);
      WIPE_ARRAY:  return 32'(ARRAY_WIPE_CYCLES - 1);
      default:     return 32'h00000000;
    endcase
  endfunction : wipe_load

  ////////////////////////////////////////////////////////////////////////////
  // Link side and crossing

  link_capture_t capture;
  logic          cs_sync;
  logic          cs_sync_d;
  logic          seen_tog;
  logic          frame_end;

  link_shifter u_link_shifter (
    .sclk    (sclk),
    .resetn  (resetn),
    .cs_n    (cs_n),
    .dq_in   (dq_in),
    .capture (capture)
  );

  select_sync u_select_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (cs_n),
    .sync_out (cs_sync)
  );

  // Select rise seen here; link contents stand still until next frame
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cs_sync_d <= SELECT_IDLE;
      seen_tog  <= 1'b0;
    end else begin
      cs_sync_d <= cs_sync;
      if (cs_sync && !cs_sync_d) begin
        seen_tog <= capture.frame_tog;
      end
    end
  end

  // A frame ends only if it saw at least one clock edge
  assign frame_end = cs_sync && !cs_sync_d && (capture.frame_tog != seen_tog);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  frame_t     frame;
  wipe_kind_t op_kind;
  wipe_kind_t next_kind;
  logic       region_locked;
  logic       is_unlock;
  logic       is_mode_entry;
  logic       accept;
  reject_t    next_reject;
  seq_state_t state;

  assign frame   = decode_frame(capture, four_line_protocol);
  assign op_kind = opcode_kind(frame.op);

  // Kind only when the frame length fits the opcode
  always_comb begin
    next_kind = WIPE_NONE;
    if (op_kind == WIPE_ARRAY && frame.len == LEN_OP) begin
      next_kind = WIPE_ARRAY;
    end else if (op_kind != WIPE_ARRAY && frame.len == LEN_OP_ADDR) begin
      next_kind = op_kind;
    end
  end

  // Protection check by region
  always_comb begin
    if (next_kind == WIPE_ARRAY) begin
      region_locked = (protect_level != 4'h0);
    end else begin
      region_locked = block_protected(protect_level,
        frame.addr[BLOCK_INDEX_MSB:BLOCK_INDEX_LSB]);
    end
  end

  assign is_unlock = frame.len == LEN_OP && frame.op == OP_WRITE_UNLOCK_CMD;
  assign is_mode_entry = frame.len == LEN_OP &&
                         frame.op == OP_FOUR_LINE_MODE_ENTRY;

  // Accept and refusal reasons for wipe opcodes
  always_comb begin
    accept      = 1'b0;
    next_reject = REJ_NONE;
    if (frame_end && op_kind != WIPE_NONE && frame.len != LEN_SHORT) begin
      if (state != SEQ_IDLE) begin
        next_reject = REJ_BUSY;
      end else if (next_kind == WIPE_NONE) begin
        next_reject = REJ_FRAMING;
      end else if (!write_unlock_latch) begin
        next_reject = REJ_NO_LATCH;
      end else if (region_locked) begin
        next_reject = REJ_PROTECTED;
      end else begin
        accept = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latches and mode

  // Unlock latch: set by unlock, cleared when a cycle starts
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      write_unlock_latch <= LATCH_RESET;
    end else if (frame_end && is_unlock && state == SEQ_IDLE) begin
      write_unlock_latch <= 1'b1;
    end else if (accept) begin
      write_unlock_latch <= 1'b0;
    end
  end

  // Four-line mode entry
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      four_line_protocol <= FOUR_LINE_RESET;
    end else if (frame_end && is_mode_entry && state == SEQ_IDLE) begin
      four_line_protocol <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Erase sequencer

  logic [31:0] remaining;

  // State, busy flag and cycle timer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state               <= SEQ_IDLE;
      busy_flag_in_status <= 1'b0;
      remaining           <= 32'h00000000;
      wipe_done           <= 1'b0;
    end else begin
      wipe_done <= 1'b0;
      unique case (state)
        SEQ_IDLE: begin
          if (accept) begin
            state               <= SEQ_WIPING;
            busy_flag_in_status <= 1'b1;
            remaining           <= wipe_load(next_kind);
          end
        end
        SEQ_WIPING: begin
          if (remaining == 32'h00000000) begin
            state               <= SEQ_IDLE;
            busy_flag_in_status <= 1'b0;
            wipe_done           <= 1'b1;
          end else begin
            remaining <= remaining - 32'h00000001;
          end
        end
        default: begin
          state               <= SEQ_IDLE;
          busy_flag_in_status <= 1'b0;
        end
      endcase
    end
  end

  // Region command to the array, all bits to one
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wipe_start    <= 1'b0;
      wipe_req.kind <= WIPE_NONE;
      wipe_req.base <= 24'h000000;
    end else begin
      wipe_start <= accept;
      if (accept) begin
        wipe_req.kind <= next_kind;
        wipe_req.base <= region_base(next_kind, frame.addr);
      end
    end
  end

  // Refusal report
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reject_pulse  <= 1'b0;
      reject_reason <= REJ_NONE;
    end else begin
      reject_pulse <= (next_reject != REJ_NONE);
      if (next_reject != REJ_NONE) begin
        reject_reason <= next_reject;
      end
    end
  end

endmodule : wipe_sequencer

`default_nettype wire

// file: dv/wipe_sequencer_props.sv
// Checker: launch, timing and refusal properties of the erase sequencer
`timescale 1ns/1ps
`default_nettype none
module wipe_sequencer_props #(
  parameter int unsigned SECTOR_WIPE_CYCLES = 20,
  parameter int unsigned HALF_WIPE_CYCLES   = 30,
  parameter int unsigned BLOCK_WIPE_CYCLES  = 40,
  parameter int unsigned ARRAY_WIPE_CYCLES  = 50
) (
  input wire logic                clock,               // System clock
  input wire logic                resetn,              // Reset, low
  input wire logic                sclk,                // Serial clock
  input wire logic                cs_n,                // Select, low
  input wire logic [3:0]          dq_in,               // Data lines
  input wire logic [3:0]          protect_level,       // Protect bits
  input wire logic                busy_flag_in_status, // Busy
  input wire logic                write_unlock_latch,  // Unlock latch
  input wire logic                four_line_protocol,  // Four-line mode
  input wire logic                wipe_start,          // Start pulse
  input wire wipe_pkg::wipe_req_t wipe_req,            // Region
  input wire logic                wipe_done,           // End pulse
  input wire logic                reject_pulse,        // Refusal pulse
  input wire wipe_pkg::reject_t   reject_reason        // Refusal cause
);
  import wipe_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  int unsigned busy_len;
  // Length of the current busy run
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) busy_len <= 0;
    else if (busy_flag_in_status) busy_len <= busy_len + 1;
    else busy_len <= 0;
  end
  function automatic int unsigned dur(wipe_kind_t k);
    case (k)
      WIPE_SECTOR: return SECTOR_WIPE_CYCLES;
      WIPE_HALF:   return HALF_WIPE_CYCLES;
      WIPE_BLOCK:  return BLOCK_WIPE_CYCLES;
      default:     return ARRAY_WIPE_CYCLES;
    endcase
  endfunction : dur
  function automatic logic [23:0] keep(wipe_kind_t k);
    case (k)
      WIPE_SECTOR: return SECTOR_MASK;
      WIPE_HALF:   return HALF_BLOCK_MASK;
      WIPE_BLOCK:  return BLOCK_MASK;
      default:     return 24'hFFFFFF;
    endcase
  endfunction : keep
  function automatic logic guarded(logic [23:0] a, logic [3:0] l);
    if (l == 4'h0) return 1'b0;
    if (l >= 4'h8) return 1'b1;
    return {1'b0, a[18:16]} >= 4'h8 - l;
  endfunction : guarded

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  sequence s_launch;
    $rose(busy_flag_in_status) && !write_unlock_latch
      ##1 busy_flag_in_status && !wipe_start;
  endsequence
  a_start_launch: assert property (wipe_start |-> s_launch)
    else $error("start without busy run");
  a_start_cause: assert property (
    wipe_start |-> $past(write_unlock_latch))
    else $error("start with latch clear");
  a_busy_length: assert property (
    wipe_done |-> busy_len == dur(wipe_req.kind))
    else $error("busy run length wrong");
  a_done_fall: assert property (
    $fell(busy_flag_in_status) |-> wipe_done)
    else $error("busy fell without done");
  a_reject_quiet: assert property (
    reject_pulse |-> reject_reason != REJ_NONE
    && !$rose(busy_flag_in_status) && !wipe_start)
    else $error("refusal started a cycle");
  a_region_free: assert property (
    wipe_start && wipe_req.kind != WIPE_ARRAY
    |-> !guarded(wipe_req.base, protect_level))
    else $error("protected region wiped");
  a_array_clear: assert property (
    wipe_start && wipe_req.kind == WIPE_ARRAY |-> protect_level == 4'h0)
    else $error("array wiped under protection");
  a_base_masked: assert property (
    wipe_start |-> (wipe_req.base & ~keep(wipe_req.kind)) == 24'h0)
    else $error("base keeps low bits");
  a_quad_sticky: assert property (!$fell(four_line_protocol))
    else $error("four-line mode dropped");
endmodule : wipe_sequencer_props

bind wipe_sequencer wipe_sequencer_props #(
  .SECTOR_WIPE_CYCLES(SECTOR_WIPE_CYCLES),
  .HALF_WIPE_CYCLES(HALF_WIPE_CYCLES),
  .BLOCK_WIPE_CYCLES(BLOCK_WIPE_CYCLES),
  .ARRAY_WIPE_CYCLES(ARRAY_WIPE_CYCLES)
) u_props (
  .clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
  .dq_in(dq_in), .protect_level(protect_level),
  .busy_flag_in_status(busy_flag_in_status),
  .write_unlock_latch(write_unlock_latch),
  .four_line_protocol(four_line_protocol), .wipe_start(wipe_start),
  .wipe_req(wipe_req), .wipe_done(wipe_done),
  .reject_pulse(reject_pulse), .reject_reason(reject_reason)
);
`default_nettype wire

// file: dv/flash_host.sv
// Partner model: host driving select, serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  output var logic       sclk,  // Serial clock, still outside frames
  output var logic       cs_n,  // Select, active low
  output var logic [3:0] dq_in  // Data lines toward the device
);
  // Idle levels
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq_in = 4'h0;
  end
  // One frame of n edges, MSB first, 48 ns serial period
  task automatic xfer(logic [31:0] w, int n, logic q);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      dq_in = q ? w[31:28] : {~dq_in[3:1], w[31]};
      w = q ? w << 4 : w << 1;
      #12 sclk = 1'b1;
      #24 sclk = 1'b0;
      #12;
    end
    dq_in = ~dq_in; // Released lines lose the last value
    cs_n = 1'b1;
  endtask : xfer
endmodule : flash_host
`default_nettype wire

// file: dv/tb_serial_flash_erase_sequencer.sv
// Testbench: erase frames, refusals, protection and four-line mode
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_erase_sequencer;
  import wipe_pkg::*;
  logic            clock = 1'b0;
  logic            resetn = 1'b0;
  wire logic       sclk;
  wire logic       cs_n;
  wire logic [3:0] dq_in;
  logic [3:0]      protect_level = 4'h0;
  logic            busy, latch, quad, start, done, rej;
  wipe_req_t       req;
  reject_t         reason;
  int              n_fail = 0;
  int              check_count = 0;
  int              cyc = 0;

  always #25 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end

  wipe_sequencer #(
    .SECTOR_WIPE_CYCLES(20), .HALF_WIPE_CYCLES(30),
    .BLOCK_WIPE_CYCLES(40), .ARRAY_WIPE_CYCLES(50)
  ) dut (
    .clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .dq_in(dq_in), .protect_level(protect_level),
    .busy_flag_in_status(busy), .write_unlock_latch(latch),
    .four_line_protocol(quad), .wipe_start(start), .wipe_req(req),
    .wipe_done(done), .reject_pulse(rej), .reject_reason(reason)
  );
  flash_host host (.sclk(sclk), .cs_n(cs_n), .dq_in(dq_in));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_pulse(output logic s, output logic r);
    s = 1'b0;
    r = 1'b0;
    for (int i = 0; i < 8 && !s && !r; i++) begin
      @(posedge clock);
      #1 s = start;
      r = rej;
    end
  endtask : wait_pulse
  task automatic unlock(logic q);
    host.xfer({OP_WRITE_UNLOCK_CMD, 24'h0}, q ? 2 : 8, q);
    repeat (6) @(posedge clock);
    #1 chk("latch set", 1, latch);
  endtask : unlock

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic wipe_ok(logic [7:0] op, logic [23:0] a, logic q,
                         wipe_kind_t k, logic [23:0] b, int n);
    logic s, r;
    int   len;
    unlock(q);
    host.xfer({op, a}, k == WIPE_ARRAY ? (q ? 2 : 8) : (q ? 8 : 32), q);
    wait_pulse(s, r);
    chk("start", 1, s);
    chk("latch cleared", 0, latch);
    chk("region", {k, b}, req);
    len = 0;
    while (busy && len < 100) begin
      @(posedge clock);
      #1 len++;
    end
    chk("busy cycles", n, len);
    chk("done", 1, done);
    repeat (4) @(posedge clock);
  endtask : wipe_ok
  task automatic wipe_bad(logic [7:0] op, logic [23:0] a, int n,
                          logic u, reject_t why);
    logic s, r;
    if (u) unlock(1'b0);
    host.xfer({op, a}, n, 1'b0);
    wait_pulse(s, r);
    chk("refused", 1, r);
    chk("reason", why, reason);
    repeat (2) @(posedge clock);
    #1 chk("still idle", 0, busy);
    repeat (4) @(posedge clock);
  endtask : wipe_bad
  task automatic wipe_busy();
    logic s, r;
    unlock(1'b0);
    host.xfer({OP_FULL_BLOCK_WIPE, 24'h010000}, 32, 1'b0);
    wait_pulse(s, r);
    chk("busy start", 1, s);
    repeat (2) @(posedge clock);
    host.xfer({OP_ARRAY_WIPE_A, 24'h0}, 8, 1'b0);
    wait_pulse(s, r);
    chk("busy refused", 1, r);
    chk("busy reason", REJ_BUSY, reason);
    chk("busy kept", 1, busy);
    repeat (40) @(posedge clock);
    #1 chk("busy over", 0, busy);
  endtask : wipe_busy

  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1 chk("reset busy", 0, busy);
    chk("reset latch", 0, latch);
    chk("reset mode", 0, quad);
    wipe_bad(OP_SMALL_REGION_WIPE, 24'h001000, 32, 0,
             REJ_NO_LATCH);
    wipe_ok(OP_SMALL_REGION_WIPE, 24'h012345, 0, WIPE_SECTOR,
            24'h012000, 20);
    wipe_ok(OP_HALF_BLOCK_WIPE, 24'h03ABCD, 0, WIPE_HALF,
            24'h038000, 30);
    wipe_ok(OP_FULL_BLOCK_WIPE, 24'h07FFFF, 0, WIPE_BLOCK,
            24'h070000, 40);
    wipe_ok(OP_ARRAY_WIPE_A, 24'h0, 0, WIPE_ARRAY, 24'h0, 50);
    wipe_bad(OP_SMALL_REGION_WIPE, 24'h001000, 31, 1,
             REJ_FRAMING);
    wipe_bad(OP_ARRAY_WIPE_B, 24'h0, 9, 1, REJ_FRAMING);
    wipe_busy();
    @(posedge clock);
    protect_level <= 4'h1;
    wipe_bad(OP_FULL_BLOCK_WIPE, 24'h070000, 32, 1,
             REJ_PROTECTED);
    wipe_ok(OP_FULL_BLOCK_WIPE, 24'h06FFFF, 0, WIPE_BLOCK,
            24'h060000, 40);
    wipe_bad(OP_ARRAY_WIPE_B, 24'h0, 8, 1, REJ_PROTECTED);
    @(posedge clock);
    protect_level <= 4'h0;
    wipe_ok(OP_ARRAY_WIPE_B, 24'h0, 0, WIPE_ARRAY, 24'h0, 50);
    host.xfer({OP_FOUR_LINE_MODE_ENTRY, 24'h0}, 8, 1'b0);
    repeat (6) @(posedge clock);
    #1 chk("four-line mode", 1, quad);
    wipe_ok(OP_FULL_BLOCK_WIPE, 24'h05A5A5, 1, WIPE_BLOCK,
            24'h050000, 40);
    wipe_ok(OP_SMALL_REGION_WIPE, 24'h0C3E97, 1, WIPE_SECTOR,
            24'h0C3000, 20);
    wipe_ok(OP_HALF_BLOCK_WIPE, 24'h04C001, 1, WIPE_HALF,
            24'h048000, 30);
    wipe_ok(OP_ARRAY_WIPE_A, 24'h0, 1, WIPE_ARRAY, 24'h0, 50);
    stop_test();
  end
endmodule : tb_serial_flash_erase_sequencer
`default_nettype wire
